// ---- src/hlru_map.vh ----
`ifndef HLRU_MAP_VH
`define HLRU_MAP_VH

// State field layout, one set
`define HLRU_STATE_W 10
`define HLRU_PAIR_LSB 6
`define HLRU_M10 5
`define HLRU_M21 4
`define HLRU_M20 3
`define HLRU_M32 2
`define HLRU_M31 1
`define HLRU_M30 0

// Legal value after reset or invalidate-all
`define HLRU_STATE_RST 10'h029

// Geometry
`define HLRU_WAYS 8
`define HLRU_SETS 64

`endif

// ---- src/hlru_replace.v ----
`timescale 1ns/1ps
`include "hlru_map.vh"

// Summary of operation
// - Every miss names one set element as victim, aiming for least recent.
// - Eight elements form four pairs; four-way picks pair, two-way picks member.
// - Each pair has one bit, written plainly on a hit to either member.
// - Even member hit writes pair bit one; odd member hit writes zero.
// - Pair bit zero chooses even member; one chooses odd member.
// - Pair order is a six-bit lower triangular matrix without diagonal.
// - Referencing pair k sets row k to one, clears column k.
// - Least recent pair has all-zero row and all-one column.
// - Hit writes three matrix bits; miss reads all six.
// - Each set holds ten state bits: six matrix, four pair bits.
// - Hit on element j updates pair j div 2 with the inverse of j mod 2.
// - Victim index is twice chosen pair plus that pair's bit.
// - Reset: [1,0],[2,0],[3,0] one; others and pair bits zero.
// - Packing: bits 9..6 pair bits, 5..0 matrix entries in fixed order.
// - Status read returns the ten bits in the packed layout.
// - One set accepts up to three updates in the same cycle: fill, port zero, port one.
// - Bit written by one port takes that port's value.
// - Bit written by both ports: port zero applied first, then port one.
// - Invalidate-all returns every set's state to reset value.
// - Locked element is never returned as victim unless all eight elements are locked.
module hlru_replace #(
	parameter SETS = `HLRU_SETS,
	parameter SET_W = 6,
	parameter WAY_W = 3
) (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Port zero access
	input wire p0_hit,
	input wire p0_miss,
	input wire [SET_W-1:0] p0_set,
	input wire [WAY_W-1:0] p0_way,
	// Port one access
	input wire p1_hit,
	input wire p1_miss,
	input wire [SET_W-1:0] p1_set,
	input wire [WAY_W-1:0] p1_way,
	// Victim answers, one cycle after the miss
	output reg p0_victim_valid,
	output reg [WAY_W-1:0] p0_victim,
	output reg p1_victim_valid,
	output reg [WAY_W-1:0] p1_victim,
	// Fill of the chosen victim
	input wire fill,
	input wire [SET_W-1:0] fill_set,
	input wire [WAY_W-1:0] fill_way,
	// Lock mask of the missing set, one bit per element
	input wire [`HLRU_WAYS-1:0] p0_lock,
	input wire [`HLRU_WAYS-1:0] p1_lock,
	// Invalidate-all
	input wire inval_all,
	// Status read
	input wire [SET_W-1:0] stat_set,
	output reg [`HLRU_STATE_W-1:0] stat_data
);

	////////////////////////////////////////////////////////////////////////////////

	reg [`HLRU_STATE_W-1:0] state_reg [0:SETS-1];
	reg [`HLRU_STATE_W-1:0] state_next [0:SETS-1];

	// six matrix bits, entry [a,b] with a above b
	function [5:0] row_set;
		input [5:0] m;
		input [1:0] k;
		reg [5:0] r;
		begin
			r = m;
			case (k)
			2'h1: begin
				r[`HLRU_M10] = 1'b1;
			end
			2'h2: begin
				r[`HLRU_M20] = 1'b1;
				r[`HLRU_M21] = 1'b1;
			end
			2'h3: begin
				r[`HLRU_M30] = 1'b1;
				r[`HLRU_M31] = 1'b1;
				r[`HLRU_M32] = 1'b1;
			end
			// Pair zero has no row
			default: begin
				r = m;
			end
			endcase
			row_set = r;
		end
	endfunction

	function [5:0] col_clear;
		input [5:0] m;
		input [1:0] k;
		reg [5:0] r;
		begin
			r = m;
			case (k)
			2'h0: begin
				r[`HLRU_M10] = 1'b0;
				r[`HLRU_M20] = 1'b0;
				r[`HLRU_M30] = 1'b0;
			end
			2'h1: begin
				r[`HLRU_M21] = 1'b0;
				r[`HLRU_M31] = 1'b0;
			end
			2'h2: begin
				r[`HLRU_M32] = 1'b0;
			end
			// Pair three has no column
			default: begin
				r = m;
			end
			endcase
			col_clear = r;
		end
	endfunction

	// Hit-style reference of element j
	function [`HLRU_STATE_W-1:0] touch;
		input [`HLRU_STATE_W-1:0] s;
		input [WAY_W-1:0] j;
		reg [1:0] k;
		reg [`HLRU_STATE_W-1:0] r;
		begin
			// pair j div 2, member j mod 2
			k = j[2:1];
			r = s;
			// matrix in the low six bits
			r[`HLRU_PAIR_LSB-1:0] = col_clear(row_set(s[`HLRU_PAIR_LSB-1:0], k), k);
			r[`HLRU_PAIR_LSB + k] = ~j[0];
			touch = r;
		end
	endfunction

	// pair ranking: entry [a,b] one means a more recent than b
	function [3:0] pair_older;
		input [`HLRU_STATE_W-1:0] s;
		begin
			pair_older[0] = s[`HLRU_M10] & s[`HLRU_M20] & s[`HLRU_M30];
			pair_older[1] = ~s[`HLRU_M10] & s[`HLRU_M21] & s[`HLRU_M31];
			pair_older[2] = ~s[`HLRU_M20] & ~s[`HLRU_M21] & s[`HLRU_M32];
			pair_older[3] = ~s[`HLRU_M30] & ~s[`HLRU_M31] & ~s[`HLRU_M32];
		end
	endfunction

	// Matrix order is total, so one pair qualifies at a time
	function [1:0] oldest_pair;
		input [3:0] old;
		begin
			case (old)
			4'h2: oldest_pair = 2'h1;
			4'h4: oldest_pair = 2'h2;
			4'h8: oldest_pair = 2'h3;
			default: oldest_pair = 2'h0;
			endcase
		end
	endfunction

	// Recency rank of pair k: count of pairs it beats
	function [1:0] pair_rank;
		input [`HLRU_STATE_W-1:0] s;
		input [1:0] k;
		reg [1:0] c;
		begin
			case (k)
			2'd0: c = {1'b0, ~s[`HLRU_M10]} + {1'b0, ~s[`HLRU_M20]} + {1'b0, ~s[`HLRU_M30]};
			2'd1: c = {1'b0, s[`HLRU_M10]} + {1'b0, ~s[`HLRU_M21]} + {1'b0, ~s[`HLRU_M31]};
			2'd2: c = {1'b0, s[`HLRU_M20]} + {1'b0, s[`HLRU_M21]} + {1'b0, ~s[`HLRU_M32]};
			default: c = {1'b0, s[`HLRU_M30]} + {1'b0, s[`HLRU_M31]} + {1'b0, s[`HLRU_M32]};
			endcase
			pair_rank = c;
		end
	endfunction

	// pair blocked when both members locked
	function pair_locked;
		input [`HLRU_WAYS-1:0] lock;
		input [1:0] k;
		begin
			pair_locked = lock[{k, 1'b0}] & lock[{k, 1'b1}];
		end
	endfunction

	// Least recent pair with a free member; relies on at least one element unlocked
	function [1:0] least_free_pair;
		input [`HLRU_STATE_W-1:0] s;
		input [`HLRU_WAYS-1:0] lock;
		reg [1:0] best;
		reg found;
		integer i;
		integer rk;
		begin
			best = 2'h0;
			found = 1'b0;
			for (rk = 0; rk < 4; rk = rk + 1) begin
				for (i = 0; i < 4; i = i + 1) begin
					if (!found && pair_rank(s, i[1:0]) == rk[1:0] && !pair_locked(lock, i[1:0])) begin
						best = i[1:0];
						found = 1'b1;
					end
				end
			end
			least_free_pair = best;
		end
	endfunction

	// Victim choice from one set's state and lock mask
	function [WAY_W-1:0] pick;
		input [`HLRU_STATE_W-1:0] s;
		input [`HLRU_WAYS-1:0] lock;
		reg [1:0] p;
		reg q;
		begin
			p = oldest_pair(pair_older(s));
			if (pair_locked(lock, p)) begin
				p = least_free_pair(s, lock);
			end
			q = s[`HLRU_PAIR_LSB + p];
			if (lock[{p, q}]) begin
				q = ~q;
			end
			// victim is two p plus q
			pick = {p, q};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	// both ports and fill merge into one next state
	genvar g;
	generate
		for (g = 0; g < SETS; g = g + 1) begin : g_set
			wire fill_here;
			wire p0_here;
			wire p1_here;
			assign fill_here = fill && (fill_set == g);
			assign p0_here = p0_hit && (p0_set == g);
			assign p1_here = p1_hit && (p1_set == g);

			always @* begin
				state_next[g] = state_reg[g];
				// fill acts like a hit, ahead of the ports
				if (fill_here) begin
					state_next[g] = touch(state_next[g], fill_way);
				end
				// port zero first, then port one
				if (p0_here) begin
					state_next[g] = touch(state_next[g], p0_way);
				end
				// port one alone keeps its own values
				if (p1_here) begin
					state_next[g] = touch(state_next[g], p1_way);
				end
			end

			always @(posedge clk) begin
				if (!reset_n) begin
					state_reg[g] <= `HLRU_STATE_RST;
				end else if (inval_all) begin
					state_reg[g] <= `HLRU_STATE_RST;
				end else begin
					state_reg[g] <= state_next[g];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////

	// Miss side reads the state before same-cycle hits land
	wire [`HLRU_STATE_W-1:0] p0_state;
	wire [`HLRU_STATE_W-1:0] p1_state;
	wire [WAY_W-1:0] p0_pick;
	wire [WAY_W-1:0] p1_pick;
	assign p0_state = state_reg[p0_set];
	assign p1_state = state_reg[p1_set];
	assign p0_pick = pick(p0_state, p0_lock);
	assign p1_pick = pick(p1_state, p1_lock);

	// port zero victim on each miss
	// Victim held until the next miss, so fill control may sample it late
	always @(posedge clk) begin
		if (!reset_n) begin
			p0_victim_valid <= 1'b0;
			p0_victim <= {WAY_W{1'b0}};
		end else begin
			p0_victim_valid <= p0_miss;
			if (p0_miss) begin
				p0_victim <= p0_pick;
			end
		end
	end

	// port one victim, same set allowed
	always @(posedge clk) begin
		if (!reset_n) begin
			p1_victim_valid <= 1'b0;
			p1_victim <= {WAY_W{1'b0}};
		end else begin
			p1_victim_valid <= p1_miss;
			if (p1_miss) begin
				p1_victim <= p1_pick;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	wire [`HLRU_STATE_W-1:0] stat_state;
	assign stat_state = state_reg[stat_set];

	always @(posedge clk) begin
		if (!reset_n) begin
			stat_data <= `HLRU_STATE_RST;
		end else begin
			stat_data <= stat_state;
		end
	end

endmodule

// ---- test/hlru_replace_sva.sv ----
`timescale 1ns/1ps
module hlru_chk #(
	parameter SET_W = 6,
	parameter WAY_W = 3
) (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Requests
	input wire p0_hit,
	input wire p0_miss,
	input wire p1_hit,
	input wire p1_miss,
	input wire fill,
	input wire inval_all,
	input wire [SET_W-1:0] p0_set,
	input wire [WAY_W-1:0] p0_way,
	input wire [7:0] p0_lock,
	input wire [SET_W-1:0] stat_set,
	// Answers
	input wire p0_victim_valid,
	input wire [WAY_W-1:0] p0_victim,
	input wire p1_victim_valid,
	input wire [9:0] stat_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	miss_answer_a: assert property (p0_miss |=> p0_victim_valid) else $error("no victim");
	dual_answer_a: assert property (p1_miss |=> p1_victim_valid) else $error("no victim 1");
	quiet_port_a: assert property (!p1_miss |=> !p1_victim_valid) else $error("stray victim");
	victim_hold_a: assert property (!p0_miss |=> $stable(p0_victim)) else $error("victim moved");
	reset_state_a: assert property ($rose(reset_n) |-> stat_data == 10'h029) else $error("bad reset");
	inval_state_a: assert property (inval_all |-> ##2 stat_data == 10'h029) else $error("bad inval");
	lock_skip_a: assert property (p0_miss |=> (($past(p0_lock) >> p0_victim) & 8'h01) == 8'h00)
		else $error("locked victim");
	pair_bit_a: assert property ((p0_hit && !p1_hit && !fill && !inval_all && stat_set == p0_set)
		##1 $stable(stat_set) |=> stat_data[6 + $past(p0_way[2:1], 2)] == !$past(p0_way[0], 2))
		else $error("bad pair bit");
endmodule
bind hlru_replace hlru_chk #(.SET_W(SET_W), .WAY_W(WAY_W)) chk_u (.*);

// ---- test/hlru_ctl_model.sv ----
`timescale 1ns/1ps
module hlru_ctl_model (
	// Clock
	input wire clk,
	// Requests toward the block
	output logic p0_hit,
	output logic p0_miss,
	output logic p1_hit,
	output logic p1_miss,
	output logic fill,
	output logic [5:0] p0_set,
	output logic [5:0] p1_set,
	output logic [2:0] p0_way,
	output logic [2:0] p1_way
);
	initial {p0_hit, p0_miss, p1_hit, p1_miss, fill, p0_set, p1_set, p0_way, p1_way} = '0;
	task automatic go(input logic [4:0] k, input logic [5:0] a, b, input logic [2:0] x, y);
		@(negedge clk);
		{p0_hit, p0_miss, p1_hit, p1_miss, fill} = k;
		{p0_set, p1_set, p0_way, p1_way} = {a, b, x, y};
		@(negedge clk);
		{p0_hit, p0_miss, p1_hit, p1_miss, fill} = 5'h00;
		// Released lines do not keep the old value
		{p0_set, p1_set, p0_way, p1_way} = ~{p0_set, p1_set, p0_way, p1_way};
	endtask
endmodule

// ---- test/tb_hlru_replace.sv ----
`timescale 1ns/1ps
module tb_hlru_replace;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic inval_all = 1'h0;
	logic p0_hit, p0_miss, p1_hit, p1_miss, fill, p0_victim_valid, p1_victim_valid;
	logic [5:0] p0_set, p1_set;
	logic [5:0] stat_set = 6'h00;
	logic [2:0] p0_way, p1_way, p0_victim, p1_victim;
	logic [7:0] lk = 8'h00;
	logic [9:0] stat_data;
	logic [2:0] wy[3] = '{3'h0, 3'h7, 3'h5};
	logic [9:0] sx[3] = '{10'h040, 10'h047, 10'h05B};
	logic [2:0] vx[3] = '{3'h6, 3'h4, 3'h2};
	int failures = 0;
	int n_tests = 0;
	int cyc = 0;
	initial forever #12.5 clk = ~clk;
	hlru_ctl_model pm_u (.*);
	hlru_replace dut_u (.*, .fill_set(p0_set), .fill_way(p0_way), .p0_lock(lk), .p1_lock(lk));
	////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic st(input logic [9:0] e);
		@(negedge clk);
		chk("state", e, stat_data);
	endtask
	task automatic miss0(input logic [5:0] s, input logic [2:0] e);
		pm_u.go(5'h08, s, 6'h00, 3'h0, 3'h0);
		chk("valid", 10'h001, p0_victim_valid);
		chk("victim", e, p0_victim);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(negedge clk);
		reset_n = 1'h1;
		stat_set = 6'h09;
		@(negedge clk);
		chk("reset", 10'h029, stat_data);
		pm_u.go(5'h02, 6'h00, 6'h09, 3'h0, 3'h0);
		chk("victim1", 10'h008, {p1_victim_valid, p1_victim});
		// Walk pairs 0, 3, 2 on one set
		stat_set = 6'h05;
		for (int i = 0; i < 3; i++) begin
			pm_u.go(5'h10, 6'h05, 6'h00, wy[i], 3'h0);
			st(sx[i]);
			miss0(6'h05, vx[i]);
		end
		lk = 8'h04;
		miss0(6'h05, 3'h3);
		lk = 8'h00;
		// Shared bit R[3,0] shows the port order
		stat_set = 6'h0C;
		pm_u.go(5'h14, 6'h0C, 6'h0C, 3'h6, 3'h1);
		st(10'h206);
		miss0(6'h0C, 3'h4);
		inval_all = 1'h1;
		@(negedge clk);
		inval_all = 1'h0;
		st(10'h029);
		stat_set = 6'h14;
		pm_u.go(5'h01, 6'h14, 6'h00, 3'h2, 3'h0);
		st(10'h0A9);
		tally_and_finish;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 500) begin
			failures++;
			tally_and_finish;
		end
	end
endmodule
